// ### shared/uts_defines.svh
`ifndef UTS_DEFINES_SVH
`define UTS_DEFINES_SVH

`define UTS_STATUS_ADDR  16'hff55
`define UTS_STATUS_RST   8'h00
`define UTS_OCC_BIT      1
`define UTS_BUSY_BIT     0
`define UTS_POWER_BIT    7
`define UTS_TXE_BIT      6
`define UTS_CLK_MHZ      100
`define UTS_BIT_NS       8680
`define UTS_BIT_CYCLES   ((`UTS_BIT_NS * `UTS_CLK_MHZ) / 1000)
`define UTS_DATA_BITS    8
`define UTS_FIFO_DEPTH   8

`endif

// ### shared/uts_pkg.sv
`default_nettype none
package uts_pkg;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } uts_rd_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uts_wr_req_t;

  typedef struct packed {
    logic [5:0] zero;
    logic       occupied;
    logic       busy;
  } uts_status_t;

  typedef enum logic [1:0] {
    UTS_IDLE,
    UTS_START,
    UTS_DATA,
    UTS_STOP
  } uts_tx_state_t;

endpackage
`default_nettype wire

// ### hw/uts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (flush_i) begin
      count_nxt = '0;
    end else if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push && !flush_i) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
          rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
      end
      count_r     <= count_nxt;
      in_ready_o  <= (count_nxt != (AW+1)'(DEPTH));
      out_valid_o <= (count_nxt != '0);
    end
  end

  full_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_r == (AW+1)'(DEPTH)) |-> !in_ready_o)
    else $error("fifo full but ready");

endmodule // uts_fifo
`default_nettype wire

// ### hw/uts_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "uts_defines.svh"
module uts_tx (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Mode register contents, kept outside this block
  input  wire logic [7:0]       mode_reg_i,
  // Transmit buffer write port
  input  wire uts_pkg::uts_wr_req_t txb_wr_i,
  output logic                  txb_ready_o,
  // Status register read port
  input  wire uts_pkg::uts_rd_req_t  rd_req_i,
  output uts_pkg::uts_status_t  rdata_o,
  // Serial line and events
  output logic                  txd_o,
  output logic                  tx_done_o,
  output uts_pkg::uts_status_t  status_o
);
  import uts_pkg::*;

  localparam logic [15:0] BIT_LAST = 16'(`UTS_BIT_CYCLES - 1);
  localparam logic [2:0]  IDX_LAST = 3'(`UTS_DATA_BITS - 1);

  function automatic logic tx_active(input logic [7:0] mode);
    return mode[`UTS_POWER_BIT] && mode[`UTS_TXE_BIT];
  endfunction

  function automatic uts_status_t status_word(input logic occ, input logic bsy);
    return '{zero: 6'h00, occupied: occ, busy: bsy};
  endfunction

  function automatic logic status_hit(input uts_rd_req_t req);
    return req.rd && (req.addr == `UTS_STATUS_ADDR);
  endfunction

  uts_tx_state_t state_r;
  logic [15:0]   bit_cnt_r;
  logic [2:0]    idx_r;
  logic [7:0]    shift_r;
  logic [7:0]    buf_r;
  logic          buf_full_r;
  logic          buf_full_nxt;
  logic          occ_r;
  logic          busy_r;
  logic          active;
  logic          push;
  logic          fifo_valid;
  logic [7:0]    fifo_data;
  logic          fifo_pop;
  logic          bit_end;
  logic          byte_end;
  logic          load;

  assign active   = tx_active(mode_reg_i);
  assign push     = txb_wr_i.valid && txb_ready_o && active;
  assign fifo_pop = fifo_valid && !buf_full_r && active;
  assign bit_end  = (bit_cnt_r == BIT_LAST);
  assign byte_end = (state_r == UTS_STOP) && bit_end;
  // Next byte loads as soon as the shifter is free or finishing
  assign load     = active && buf_full_r && ((state_r == UTS_IDLE) || byte_end);

  uts_fifo #(
    .WIDTH (`UTS_DATA_BITS),
    .DEPTH (`UTS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .flush_i     (!active),
    .in_valid_i  (txb_wr_i.valid && active),
    .in_data_i   (txb_wr_i.data),
    .in_ready_o  (txb_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (!buf_full_r && active)
  );

  // Transmit buffer register
  always_comb begin
    buf_full_nxt = buf_full_r;
    if (!active) begin
      buf_full_nxt = 1'b0;
    end else if (fifo_pop) begin
      buf_full_nxt = 1'b1;
    end else if (load) begin
      buf_full_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_r      <= 8'h00;
      buf_full_r <= 1'b0;
    end else if (ce_i) begin
      if (fifo_pop) begin
        buf_r <= fifo_data;
      end
      buf_full_r <= buf_full_nxt;
    end
  end

  // Shifter: start bit, eight data bits LSB first, stop bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r   <= UTS_IDLE;
      bit_cnt_r <= 16'h0000;
      idx_r     <= 3'h0;
      shift_r   <= 8'h00;
      txd_o     <= 1'b1;
    end else if (ce_i) begin
      if (!active) begin
        state_r   <= UTS_IDLE;
        bit_cnt_r <= 16'h0000;
        txd_o     <= 1'b1;
      end else if (load) begin
        state_r   <= UTS_START;
        bit_cnt_r <= 16'h0000;
        idx_r     <= 3'h0;
        shift_r   <= buf_r;
        txd_o     <= 1'b0;
      end else begin
        bit_cnt_r <= bit_end ? 16'h0000 : bit_cnt_r + 16'h0001;
        unique case (state_r)
          UTS_IDLE: begin
            bit_cnt_r <= 16'h0000;
            txd_o     <= 1'b1;
          end
          UTS_START: begin
            if (bit_end) begin
              state_r <= UTS_DATA;
              txd_o   <= shift_r[0];
            end
          end
          UTS_DATA: begin
            if (bit_end) begin
              if (idx_r == IDX_LAST) begin
                state_r <= UTS_STOP;
                txd_o   <= 1'b1;
              end else begin
                idx_r   <= idx_r + 3'h1;
                shift_r <= {1'b0, shift_r[7:1]};
                txd_o   <= shift_r[1];
              end
            end
          end
          UTS_STOP: begin
            if (bit_end) begin
              state_r <= UTS_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Completion event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_done_o <= 1'b0;
    end else if (ce_i) begin
      tx_done_o <= active && byte_end;
    end
  end

  // Status flags; a write in the same cycle as a transfer keeps the flag set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      occ_r  <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce_i) begin
      occ_r  <= active && (push || fifo_valid || buf_full_nxt);
      busy_r <= active && (load || ((state_r != UTS_IDLE) && !byte_end));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= `UTS_STATUS_RST;
      rdata_o  <= `UTS_STATUS_RST;
    end else if (ce_i) begin
      status_o <= status_word(occ_r, busy_r);
      if (status_hit(rd_req_i)) begin
        rdata_o <= status_word(occ_r, busy_r);
      end else begin
        rdata_o <= `UTS_STATUS_RST;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_end_with_next;
    ce_i && active && byte_end && buf_full_r;
  endsequence

  sequence s_start_bit;
    (state_r == UTS_START) && !txd_o && busy_r;
  endsequence

  status_upper_zero_a: assert property (rdata_o.zero == 6'h00 && status_o.zero == 6'h00)
    else $error("status upper bits not zero");

  status_read_a: assert property (ce_i && status_hit(rd_req_i)
    |=> rdata_o.occupied == $past(occ_r) && rdata_o.busy == $past(busy_r))
    else $error("status read mismatch");

  disable_clears_a: assert property (ce_i && !active
    |=> !occ_r && !busy_r ##1 (!$past(ce_i) || status_o == `UTS_STATUS_RST))
    else $error("status not cleared when disabled");

  write_sets_a: assert property (ce_i && push |=> occ_r)
    else $error("buffer flag not set on write");

  move_clears_a: assert property (ce_i && load && !fifo_valid && !push |=> !occ_r && !buf_full_r)
    else $error("buffer flag not cleared on transfer");

  load_busy_a: assert property (ce_i && load |=> s_start_bit)
    else $error("shift flag not set on load");

  end_idle_a: assert property (ce_i && active && byte_end && !buf_full_r |=> !busy_r && txd_o)
    else $error("shift flag not cleared after last byte");

  back_to_back_a: assert property (s_end_with_next |=> s_start_bit)
    else $error("gap between buffered bytes");

  mode_gate_a: assert property (ce_i && !mode_reg_i[`UTS_POWER_BIT] |=> !busy_r && state_r == UTS_IDLE)
    else $error("shifter runs with power off");

  done_pulse_a: assert property (ce_i && active && byte_end |=> tx_done_o)
    else $error("completion event missing");

  sequence s_shut_down;
    ce_i && !active;
  endsequence

  sequence s_frozen;
    !ce_i;
  endsequence

  status_mirror_a: assert property (
    ce_i
    |=> status_o == status_word($past(occ_r), $past(busy_r)))
    else $error("status mirror lags flags");

  other_addr_zero_a: assert property (
    ce_i && !status_hit(rd_req_i)
    |=> rdata_o == `UTS_STATUS_RST)
    else $error("unmapped read returned data");

  flush_ready_a: assert property (
    s_shut_down
    |=> txb_ready_o && !fifo_valid && !buf_full_r)
    else $error("queue not flushed when disabled");

  occ_covers_data_a: assert property (
    !occ_r
    |-> !fifo_valid && !buf_full_r)
    else $error("data held with buffer flag clear");

  busy_state_a: assert property (
    busy_r == (state_r != UTS_IDLE))
    else $error("shift flag disagrees with shifter");

  busy_holds_a: assert property (
    ce_i && active && (state_r != UTS_IDLE) && !byte_end
    |=> busy_r && (state_r != UTS_IDLE))
    else $error("shift flag dropped mid byte");

  idle_line_a: assert property (
    (state_r == UTS_IDLE)
    |-> txd_o)
    else $error("line low while idle");

  start_low_a: assert property (
    (state_r == UTS_START)
    |-> !txd_o)
    else $error("start bit not low");

  stop_high_a: assert property (
    (state_r == UTS_STOP)
    |-> txd_o)
    else $error("stop bit not high");

  bit_time_a: assert property (
    bit_cnt_r <= BIT_LAST)
    else $error("bit counter past bit period");

  txe_gate_a: assert property (
    ce_i && !mode_reg_i[`UTS_TXE_BIT]
    |=> !busy_r && !occ_r && txd_o)
    else $error("shifter runs with transmit disabled");

  done_only_end_a: assert property (
    ce_i && !(active && byte_end)
    |=> !tx_done_o)
    else $error("completion event without byte end");

  freeze_hold_a: assert property (
    s_frozen
    |=> $stable(state_r) && $stable(bit_cnt_r) && $stable(txd_o)
        && $stable(occ_r) && $stable(busy_r) && $stable(buf_full_r))
    else $error("state moved while clock enable low");

endmodule // uts_tx
`default_nettype wire

// ### bench/uts_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module uts_rx_model #(
  parameter int BIT_CYCLES = 868
) (
  // Line from the transmitter
  input  wire logic clk_i,
  input  wire logic line_i
);
  logic [7:0] got[$];
  int         starts[$];
  int         cyc = 0;
  int         frame_errs = 0;
  logic [7:0] b;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end

  // Samples each bit in its middle, LSB first, then checks the stop bit
  initial begin
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        starts.push_back(cyc);
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk_i);
          b[i] = line_i;
        end
        repeat (BIT_CYCLES) @(posedge clk_i);
        if (line_i === 1'b1) got.push_back(b);
        else frame_errs++;
      end
    end
  end
endmodule // uts_rx_model
`default_nettype wire

// ### bench/uts_tx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uts_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module uts_tx_tb_top;
  import uts_pkg::*;
  localparam int BITC = `UTS_BIT_CYCLES;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic [7:0]  mode_reg_i;
  uts_wr_req_t txb_wr_i;
  uts_rd_req_t rd_req_i;
  logic        txb_ready_o;
  logic        txd_o;
  logic        tx_done_o;
  uts_status_t rdata_o;
  uts_status_t status_o;
  int          bad_count = 0;
  int          comparisons = 0;
  int          dones = 0;
  int          acc;
  logic [7:0]  d;
  logic [7:0]  rd_v;
  logic [7:0]  exp_q[$];
  logic [7:0]  kills[2] = '{8'h40, 8'h80};
  logic [7:0]  offs[3] = '{8'h00, 8'h40, 8'h80};

  uts_tx i_uts_tx (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_reg_i(mode_reg_i),
    .txb_wr_i(txb_wr_i), .txb_ready_o(txb_ready_o), .rd_req_i(rd_req_i), .rdata_o(rdata_o),
    .txd_o(txd_o), .tx_done_o(tx_done_o), .status_o(status_o));
  uts_rx_model #(.BIT_CYCLES(BITC)) i_uts_rx_model (.clk_i(clk_i), .line_i(txd_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (tx_done_o === 1'b1) dones <= dones + 1;
  end

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd_status(input logic [15:0] a);
    @(posedge clk_i) rd_req_i <= '{rd: 1'b1, addr: a};
    @(posedge clk_i) rd_req_i <= '{rd: 1'b0, addr: 16'h0000};
    #1 rd_v = rdata_o;
  endtask

  task automatic wr_byte(input logic [7:0] v);
    @(posedge clk_i) txb_wr_i <= '{valid: 1'b1, data: v};
    @(posedge clk_i) txb_wr_i <= '{valid: 1'b0, data: 8'h00};
  endtask

  task automatic wait_done();
    int n;
    n = dones;
    for (int i = 0; i < 20 * BITC && dones == n; i++) @(posedge clk_i);
    if (dones == n) begin
      bad_count++;
      $display("Error %0t: completion wait timed out", $time);
      conclude();
    end
  endtask

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    mode_reg_i = 8'h00;
    txb_wr_i = '0;
    rd_req_i = '0;
    void'($urandom(6223));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `CHK(status_o, 8'h00)
    `CHK(txd_o, 1'b1)
    rd_status(16'hff55);
    `CHK(rd_v, 8'h00)
    $display("Test reset done");
    foreach (offs[k]) begin
      @(posedge clk_i) mode_reg_i <= offs[k];
      wr_byte(8'($urandom));
      repeat (5) @(posedge clk_i);
      rd_status(16'hff55);
      `CHK(rd_v, 8'h00)
      `CHK(txd_o, 1'b1)
    end
    $display("Test inactive modes done");
    @(posedge clk_i) mode_reg_i <= 8'hc0;
    d = 8'($urandom);
    exp_q.push_back(d);
    wr_byte(d);
    for (int i = 0; i < 20; i++) begin
      rd_status(16'hff55);
      if (rd_v[1] === 1'b0) break;
    end
    `CHK(rd_v, 8'h01)
    d = 8'($urandom);
    exp_q.push_back(d);
    wr_byte(d);
    repeat (4) @(posedge clk_i);
    rd_status(16'hff55);
    `CHK(rd_v, 8'h03)
    rd_status(16'hff54);
    `CHK(rd_v, 8'h00)
    wait_done();
    repeat (4) @(posedge clk_i);
    rd_status(16'hff55);
    `CHK(rd_v, 8'h01)
    wait_done();
    repeat (4) @(posedge clk_i);
    rd_status(16'hff55);
    `CHK(rd_v, 8'h00)
    `CHK(dones, 2)
    `CHK(i_uts_rx_model.got.size(), 2)
    foreach (exp_q[i]) `CHK(i_uts_rx_model.got[i], exp_q[i])
    `CHK(i_uts_rx_model.starts[1] - i_uts_rx_model.starts[0], 10 * BITC)
    `CHK(i_uts_rx_model.frame_errs, 0)
    $display("Test continuous send done");
    foreach (kills[k]) begin
      acc = 0;
      for (int i = 0; i < 13; i++) begin
        @(posedge clk_i);
        if (txb_wr_i.valid && txb_ready_o === 1'b1) acc++;
        txb_wr_i <= (i < 12) ? '{valid: 1'b1, data: 8'($urandom)} : '0;
      end
      #1 `CHK(acc, 10)
      rd_status(16'hff55);
      `CHK(rd_v, 8'h03)
      acc = dones;
      @(posedge clk_i) ce_i <= 1'b0;
      @(posedge clk_i);
      #1 d[0] = txd_o;
      repeat (10 * BITC) @(posedge clk_i);
      #1 `CHK(status_o, 8'h03)
      `CHK(txd_o, d[0])
      `CHK(dones, acc)
      @(posedge clk_i) ce_i <= 1'b1;
      @(posedge clk_i) mode_reg_i <= kills[k];
      repeat (2) @(posedge clk_i);
      rd_status(16'hff55);
      `CHK(rd_v, 8'h00)
      `CHK(status_o, 8'h00)
      `CHK(txd_o, 1'b1)
      `CHK(txb_ready_o, 1'b1)
      repeat (10 * BITC + 10) @(posedge clk_i);
      i_uts_rx_model.got.delete();
      @(posedge clk_i) mode_reg_i <= 8'hc0;
    end
    $display("Test fill and shutdown done");
    conclude();
  end
endmodule // uts_tx_tb_top
`default_nettype wire
